// ==== verilog/hfence_map.vh ====
// constants for the hypervisor translation fence unit
`ifndef HFENCE_MAP_VH
`define HFENCE_MAP_VH

// register byte offsets
`define REG_CTRL 5'h00
`define REG_GUEST_ID 5'h04
`define REG_STATUS 5'h08
`define REG_FENCE_COUNT 5'h0C
`define REG_FAULT_COUNT 5'h10

// control fields
`define CTRL_TVM_BIT 0
`define CTRL_HYPERVISOR_TRAP_VIRTUAL_MEMORY_BIT 1
`define CTRL_SCOPE_LO 2
`define CTRL_SCOPE_HI 3
`define CTRL_UNIFIED_BIT 4
`define CTRL_WIDTH 5
`define CTRL_RESET 5'h00
`define GUEST_ID_RESET 16'h0000

// flush scope policy
`define SCOPE_PRECISE 2'h0
`define SCOPE_ALL_VM 2'h1
`define SCOPE_ALL 2'h2

// request kinds
`define KIND_SFENCE 2'h0
`define KIND_VS_FENCE 2'h1
`define KIND_G_FENCE 2'h2

// privilege codes
`define PRIV_U 2'h0
`define PRIV_S 2'h1
`define PRIV_M 2'h3

// flush stage codes
`define STAGE_HOST 2'h0
`define STAGE_VS 2'h1
`define STAGE_G 2'h2

// architectural identifier widths
`define ASID_ARCH_WIDTH 16
`define VMID_ARCH_WIDTH 14

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== verilog/fence_regs.v ====
// AXI4-Lite register slave of the fence unit
`timescale 1ns/1ps
`default_nettype none
`include "hfence_map.vh"

module fence_regs (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // write channels
    input wire [4:0] s_awaddr,
    input wire s_awvalid,
    output reg s_awready,
    input wire [31:0] s_wdata,
    input wire [3:0] s_wstrb,
    input wire s_wvalid,
    output reg s_wready,
    output reg [1:0] s_bresp,
    output reg s_bvalid,
    input wire s_bready,
    // read channels
    input wire [4:0] s_araddr,
    input wire s_arvalid,
    output reg s_arready,
    output reg [31:0] s_rdata,
    output reg [1:0] s_rresp,
    output reg s_rvalid,
    input wire s_rready,
    // register contents
    output reg [`CTRL_WIDTH-1:0] ctrl_q,
    output reg [15:0] guest_id_q,
    input wire [31:0] status_in,
    input wire [31:0] fence_count_in,
    input wire [31:0] fault_count_in
);

reg [4:0] awaddr_q;
reg aw_have_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
reg w_have_q;
reg [31:0] rd_mux;
reg rd_ok;

// ----------------------------------------
// write path
// ----------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        s_awready <= 1'b1;
        s_wready <= 1'b1;
        s_bvalid <= 1'b0;
        s_bresp <= `RESP_OKAY;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        awaddr_q <= 5'h00;
        wdata_q <= 32'h00000000;
        wstrb_q <= 4'h0;
        ctrl_q <= `CTRL_RESET;
        guest_id_q <= `GUEST_ID_RESET;
    end else begin
        if (s_awvalid && s_awready) begin
            awaddr_q <= s_awaddr;
            aw_have_q <= 1'b1;
            s_awready <= 1'b0;
        end
        if (s_wvalid && s_wready) begin
            wdata_q <= s_wdata;
            wstrb_q <= s_wstrb;
            w_have_q <= 1'b1;
            s_wready <= 1'b0;
        end
        // both halves held: commit and answer
        if (aw_have_q && w_have_q && !s_bvalid) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp <= `RESP_OKAY;
            case (awaddr_q[4:2])
                3'h0: begin
                    if (wstrb_q[0]) ctrl_q <= wdata_q[`CTRL_WIDTH-1:0];
                end
                3'h1: begin
                    if (wstrb_q[0]) guest_id_q[7:0] <= wdata_q[7:0];
                    if (wstrb_q[1]) guest_id_q[15:8] <= wdata_q[15:8];
                end
                3'h2, 3'h3, 3'h4: s_bresp <= `RESP_OKAY;
                default: s_bresp <= `RESP_SLVERR;
            endcase
        end
        if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
            s_awready <= 1'b1;
            s_wready <= 1'b1;
        end
    end
end

// ----------------------------------------
// read path
// ----------------------------------------
always @* begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    case (s_araddr)
        `REG_CTRL: rd_mux = {27'h0000000, ctrl_q};
        `REG_GUEST_ID: rd_mux = {16'h0000, guest_id_q};
        `REG_STATUS: rd_mux = status_in;
        `REG_FENCE_COUNT: rd_mux = fence_count_in;
        `REG_FAULT_COUNT: rd_mux = fault_count_in;
        default: rd_ok = 1'b0;
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_arready <= 1'b1;
        s_rvalid <= 1'b0;
        s_rdata <= 32'h00000000;
        s_rresp <= `RESP_OKAY;
    end else begin
        if (s_arvalid && s_arready) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b1;
            s_rdata <= rd_mux;
            s_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
            s_arready <= 1'b1;
        end
    end
end

endmodule // fence_regs
`default_nettype wire

// ==== verilog/hypervisor_tlb_fence.v ====
// hypervisor translation fence execution unit
// Notes on behaviour
// (RULE_01) vs_stage_fence legal only in machine or hypervisor-supervisor mode
// (RULE_02) after vs_stage_fence, earlier stores precede same-guest VS-stage walks
// (RULE_03) VS-stage walks of another guest id need not wait
// (RULE_04) nonzero rs1 picks one guest address, nonzero rs2 one guest ASID
// (RULE_05) vs_stage_fence limited to the guest id current at execution
// (RULE_06) ASID bits above implemented_asid_width ignored; software zeroes reserved bits
// (RULE_07) vs_stage_fence may widen to all guests or all structures
// (RULE_08) trap-virtual-memory bits never trap vs_stage_fence
// (RULE_09) g_stage_fence legal in machine mode; in HS only when trap bit clear
// (RULE_10) after g_stage_fence, earlier stores precede all G-stage walks
// (RULE_11) g_stage_fence rs1 is guest physical address >> 2, rs2 a guest id
// (RULE_12) split caches: g_stage_fence flushes matching second-level entries
// (RULE_13) unified cache: flush matching address, or all of the guest id
// (RULE_14) guest id bits above implemented_guest_id_width ignored
// (RULE_15) g_stage_fence may widen to all guests or all structures
// (RULE_16) software fences G-stage with rs1=x0 after a guest mode change
// (RULE_17) virtual mode gives virtual-instruction fault; user mode illegal-instruction
// (RULE_18) g_stage_fence in HS with machine trap bit set is illegal
// (RULE_19) supervisor_translation_fence acts on the root in use for V
// (RULE_20) invalidation completes before any ordered later walk proceeds
`timescale 1ns/1ps
`default_nettype none
`include "hfence_map.vh"

module hypervisor_tlb_fence #(
    parameter XLEN = 64,
    parameter ASID_W = 16,
    parameter VMID_W = 14
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite slave
    input wire [4:0] s_awaddr,
    input wire s_awvalid,
    output wire s_awready,
    input wire [31:0] s_wdata,
    input wire [3:0] s_wstrb,
    input wire s_wvalid,
    output wire s_wready,
    output wire [1:0] s_bresp,
    output wire s_bvalid,
    input wire s_bready,
    input wire [4:0] s_araddr,
    input wire s_arvalid,
    output wire s_arready,
    output wire [31:0] s_rdata,
    output wire [1:0] s_rresp,
    output wire s_rvalid,
    input wire s_rready,
    // fence request from the pipeline
    input wire req_valid,
    output reg req_ready,
    input wire [1:0] req_kind,
    input wire [1:0] req_priv,
    input wire req_virt,
    input wire req_rs1_zero,
    input wire req_rs2_zero,
    input wire [XLEN-1:0] req_rs1_val,
    input wire [XLEN-1:0] req_rs2_val,
    // completion to the pipeline
    output reg done_valid,
    output reg done_illegal,
    output reg done_virtual,
    // store ordering
    input wire stores_visible,
    // walker hold
    output reg walk_hold_vs,
    output reg walk_hold_g,
    output reg walk_hold_host,
    output reg walk_hold_any_vmid,
    output reg [VMID_W-1:0] walk_hold_vmid,
    // translation cache flush
    output reg flush_valid,
    input wire flush_ack,
    output reg [1:0] flush_stage,
    output reg flush_all,
    output reg flush_use_addr,
    output reg flush_use_asid,
    output reg flush_use_vmid,
    output reg flush_combined,
    output reg [XLEN-1:0] flush_addr,
    output reg [ASID_W-1:0] flush_asid,
    output reg [VMID_W-1:0] flush_vmid
);

// ----------------------------------------
// states
// ----------------------------------------
localparam ST_IDLE = 2'h0;
localparam ST_DRAIN = 2'h1;
localparam ST_FLUSH = 2'h2;
localparam ST_DONE = 2'h3;

reg [1:0] state_q;
reg [31:0] fence_count_q;
reg [31:0] fault_count_q;
wire [`CTRL_WIDTH-1:0] ctrl_q;
wire [15:0] guest_id_q;
wire machine_trap_virtual_memory;
wire [1:0] scope;
wire unified;
wire [VMID_W-1:0] cur_vmid;
reg fault_illegal;
reg fault_virtual;
reg [1:0] stage_d;

assign machine_trap_virtual_memory = ctrl_q[`CTRL_TVM_BIT];
assign scope = ctrl_q[`CTRL_SCOPE_HI:`CTRL_SCOPE_LO];
assign unified = ctrl_q[`CTRL_UNIFIED_BIT];
assign cur_vmid = guest_id_q[VMID_W-1:0];

// ----------------------------------------
// register slave
// ----------------------------------------
fence_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .ctrl_q(ctrl_q),
    .guest_id_q(guest_id_q),
    .status_in({24'h000000, walk_hold_g, walk_hold_vs, walk_hold_host, flush_valid, 2'h0, state_q}),
    .fence_count_in(fence_count_q),
    .fault_count_in(fault_count_q)
);

// ----------------------------------------
// legality
// ----------------------------------------
always @* begin
    fault_illegal = 1'b0;
    fault_virtual = 1'b0;
    stage_d = `STAGE_HOST;
    case (req_kind)
        `KIND_VS_FENCE: begin
            // (RULE_17) virtual mode and user mode faults
            if (req_virt)
                fault_virtual = 1'b1;
            // (RULE_01) machine or HS only
            else if (req_priv == `PRIV_U)
                fault_illegal = 1'b1;
            // (RULE_08) no trap-bit check here
            stage_d = `STAGE_VS;
        end
        `KIND_G_FENCE: begin
            // (RULE_17) virtual mode and user mode faults
            if (req_virt)
                fault_virtual = 1'b1;
            else if (req_priv == `PRIV_U)
                fault_illegal = 1'b1;
            // (RULE_18) HS with trap bit set
            else if (req_priv == `PRIV_S && machine_trap_virtual_memory)
                fault_illegal = 1'b1;
            // (RULE_09) machine mode ignores trap bit
            stage_d = `STAGE_G;
        end
        `KIND_SFENCE: begin
            if (req_priv == `PRIV_U)
                fault_illegal = 1'b1;
            // (RULE_19) root chosen by V
            stage_d = req_virt ? `STAGE_VS : `STAGE_HOST;
        end
        default: fault_illegal = 1'b1;
    endcase
end

// ----------------------------------------
// fence sequencer
// ----------------------------------------
// walks are held from acceptance to flush ack, so a stale entry can never be refilled
// from tables written before the fence; the price is a stall of every ordered walk.
always @(posedge aclk) begin
    if (!aresetn) begin
        state_q <= ST_IDLE;
        req_ready <= 1'b1;
        done_valid <= 1'b0;
        done_illegal <= 1'b0;
        done_virtual <= 1'b0;
        walk_hold_vs <= 1'b0;
        walk_hold_g <= 1'b0;
        walk_hold_host <= 1'b0;
        walk_hold_any_vmid <= 1'b0;
        walk_hold_vmid <= {VMID_W{1'b0}};
        flush_valid <= 1'b0;
        flush_stage <= `STAGE_HOST;
        flush_all <= 1'b0;
        flush_use_addr <= 1'b0;
        flush_use_asid <= 1'b0;
        flush_use_vmid <= 1'b0;
        flush_combined <= 1'b0;
        flush_addr <= {XLEN{1'b0}};
        flush_asid <= {ASID_W{1'b0}};
        flush_vmid <= {VMID_W{1'b0}};
        fence_count_q <= 32'h00000000;
        fault_count_q <= 32'h00000000;
    end else begin
        done_valid <= 1'b0;
        done_illegal <= 1'b0;
        done_virtual <= 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (req_valid) begin
                    req_ready <= 1'b0;
                    if (fault_illegal || fault_virtual) begin
                        done_illegal <= fault_illegal;
                        done_virtual <= fault_virtual;
                        fault_count_q <= fault_count_q + 32'h00000001;
                        state_q <= ST_DONE;
                    end else begin
                        state_q <= ST_DRAIN;
                        flush_stage <= stage_d;
                        // (RULE_04) zero register means all
                        flush_use_addr <= !req_rs1_zero;
                        // (RULE_11) g-stage rs1 already holds address >> 2
                        flush_addr <= req_rs1_val;
                        flush_use_asid <= (stage_d != `STAGE_G) && !req_rs2_zero;
                        // (RULE_06) only implemented ASID bits kept
                        flush_asid <= req_rs2_val[ASID_W-1:0];
                        flush_all <= 1'b0;
                        flush_combined <= unified && (stage_d == `STAGE_G);
                        if (stage_d == `STAGE_G) begin
                            // (RULE_14) only implemented guest id bits kept
                            flush_vmid <= req_rs2_val[VMID_W-1:0];
                            // (RULE_12) split caches match address and guest id
                            flush_use_vmid <= !req_rs2_zero;
                            // (RULE_13) unified cache drops the address match
                            if (unified)
                                flush_use_addr <= 1'b0;
                            // (RULE_10) hold every G-stage walk
                            walk_hold_g <= 1'b1;
                            walk_hold_any_vmid <= 1'b1;
                        end else begin
                            // (RULE_05) guest id taken at execution
                            flush_vmid <= cur_vmid;
                            flush_use_vmid <= (stage_d == `STAGE_VS);
                            walk_hold_vmid <= cur_vmid;
                            // (RULE_02) hold same-guest VS-stage walks
                            walk_hold_vs <= (stage_d == `STAGE_VS);
                            walk_hold_host <= (stage_d == `STAGE_HOST);
                            // (RULE_03) other guest ids keep walking
                            walk_hold_any_vmid <= 1'b0;
                        end
                        // (RULE_07) (RULE_15) optional widening by policy
                        if (scope == `SCOPE_ALL_VM) begin
                            flush_use_addr <= 1'b0;
                            flush_use_asid <= 1'b0;
                            flush_use_vmid <= 1'b0;
                            walk_hold_any_vmid <= 1'b1;
                        end else if (scope == `SCOPE_ALL) begin
                            flush_all <= 1'b1;
                            flush_use_addr <= 1'b0;
                            flush_use_asid <= 1'b0;
                            flush_use_vmid <= 1'b0;
                            walk_hold_vs <= 1'b1;
                            walk_hold_g <= 1'b1;
                            walk_hold_host <= 1'b1;
                            walk_hold_any_vmid <= 1'b1;
                        end
                    end
                end
            end
            ST_DRAIN: begin
                // (RULE_02) (RULE_10) wait for earlier stores
                if (stores_visible) begin
                    flush_valid <= 1'b1;
                    state_q <= ST_FLUSH;
                end
            end
            ST_FLUSH: begin
                // (RULE_20) release walks only after flush ack
                if (flush_ack) begin
                    flush_valid <= 1'b0;
                    walk_hold_vs <= 1'b0;
                    walk_hold_g <= 1'b0;
                    walk_hold_host <= 1'b0;
                    walk_hold_any_vmid <= 1'b0;
                    done_valid <= 1'b1;
                    fence_count_q <= fence_count_q + 32'h00000001;
                    state_q <= ST_DONE;
                end
            end
            ST_DONE: begin
                req_ready <= 1'b1;
                state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
        endcase
        // faults also report through done_valid
        if (state_q == ST_IDLE && req_valid && (fault_illegal || fault_virtual))
            done_valid <= 1'b1;
    end
end

endmodule // hypervisor_tlb_fence
`default_nettype wire

// ==== test/hfence_chk.sv ====
// assertion checker for the hypervisor fence unit
`timescale 1ns/1ps
`default_nettype none
`include "hfence_map.vh"
module hfence_chk #(
    parameter XLEN = 64
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // request and completion
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [1:0] req_kind,
    input wire logic [1:0] req_priv,
    input wire logic req_virt,
    input wire logic done_valid,
    input wire logic done_illegal,
    input wire logic done_virtual,
    // ordering and flush
    input wire logic stores_visible,
    input wire logic walk_hold_vs,
    input wire logic walk_hold_g,
    input wire logic walk_hold_host,
    input wire logic flush_valid,
    input wire logic flush_ack,
    input wire logic [1:0] flush_stage,
    input wire logic [XLEN-1:0] flush_addr
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ----------
    // sequences
    // ----------
    sequence s_take;
        req_valid && req_ready;
    endsequence
    sequence s_ok;
        done_valid && !done_illegal && !done_virtual;
    endsequence
    // a legal fence never answers in the two cycles after acceptance
    sequence s_legal;
        !done_valid [*2] ##[1:300] s_ok;
    endsequence
    // ----------
    // properties
    // ----------
    a_virt_fault:
        assert property (s_take ##0 (req_virt && ^req_kind) |=> done_valid && done_virtual && !done_illegal) else $error("virtual fault missing");
    a_user_illegal:
        assert property (s_take ##0 (!req_virt && req_priv == `PRIV_U) |=> done_valid && done_illegal && !done_virtual) else $error("user fault missing");
    a_vs_no_trap:
        assert property (s_take ##0 (!req_virt && req_kind == `KIND_VS_FENCE && req_priv != `PRIV_U) |=> s_legal) else $error("vs fence refused");
    a_g_machine:
        assert property (s_take ##0 (!req_virt && req_kind == `KIND_G_FENCE && req_priv == `PRIV_M) |=> s_legal) else $error("g fence refused");
    a_store_first:
        assert property ($rose(flush_valid) |-> $past(stores_visible)) else $error("flush before stores visible");
    a_hold_flush:
        assert property (flush_valid |-> walk_hold_vs || walk_hold_g || walk_hold_host) else $error("walks not held");
    a_ack_done:
        assert property (flush_valid && flush_ack |=> s_ok ##0 !flush_valid) else $error("no completion after ack");
    a_flush_steady:
        assert property (flush_valid && !flush_ack |=> flush_valid && $stable(flush_addr) && $stable(flush_stage)) else $error("flush dropped");
    a_fault_late:
        assert property (done_valid && (done_illegal || done_virtual) |-> $past(req_valid) && $past(req_ready) && !flush_valid) else $error("fault timing");
endmodule // hfence_chk
bind hypervisor_tlb_fence hfence_chk #(.XLEN(XLEN)) i_hfence_chk (.*);
`default_nettype wire

// ==== test/flush_partner.sv ====
// flush responder standing in for the translation caches
`timescale 1ns/1ps
`default_nettype none
module flush_partner (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // flush handshake
    input wire logic flush_valid,
    input wire logic [3:0] ack_delay,
    output logic flush_ack
);
    logic [3:0] wait_q;
    always @(posedge aclk) begin
        if (!aresetn || flush_ack || !flush_valid) begin
            wait_q <= 4'h0;
            flush_ack <= 1'b0;
        end else begin
            wait_q <= wait_q + 4'h1;
            flush_ack <= wait_q >= ack_delay;
        end
    end
endmodule // flush_partner
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench for the hypervisor fence unit
`timescale 1ns/1ps
`default_nettype none
`include "hfence_map.vh"
module tb;
    logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, got;
    logic [4:0] s_awaddr, s_araddr, ctl, nc;
    logic [31:0] s_wdata;
    wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    wire [1:0] s_bresp, s_rresp, flush_stage;
    wire [31:0] s_rdata;
    logic req_valid, req_virt, req_rs1_zero, req_rs2_zero, stores_visible;
    logic [1:0] req_kind, req_priv, p;
    logic [63:0] req_rs1_val, req_rs2_val;
    wire req_ready, done_valid, done_illegal, done_virtual, flush_valid, flush_ack, flush_all, flush_combined;
    wire walk_hold_vs, walk_hold_g, walk_hold_host, walk_hold_any_vmid, flush_use_addr, flush_use_asid, flush_use_vmid;
    wire [13:0] walk_hold_vmid, flush_vmid;
    wire [15:0] flush_asid;
    wire [63:0] flush_addr;
    logic [3:0] ack_delay;
    logic [15:0] gid;
    logic [11:0] corner [0:12];
    logic [100:0] cap;
    integer n_fail, check_count, seed, n_ok, n_bad, n_flush, i, r, rnd;
    hypervisor_tlb_fence i_hypervisor_tlb_fence (.*, .s_wstrb(4'hF));
    flush_partner i_flush_partner (.aclk, .aresetn, .flush_valid, .ack_delay, .flush_ack);
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // pipeline store drain and cache answer speed vary every cycle
    always @(posedge aclk) begin
        rnd = $random(seed);
        stores_visible <= rnd[0];
        ack_delay <= {1'b0, rnd[3:1]};
        if (flush_valid && flush_ack) begin
            n_flush <= n_flush + 1;
            cap <= {flush_stage, flush_all, flush_use_addr, flush_use_asid, flush_use_vmid, flush_combined,
                flush_asid, flush_vmid, flush_addr};
        end
    end
    // ----------
    // expectations and bus tasks
    // ----------
    function logic [1:0] exp_fault(input logic [1:0] k, input logic [1:0] pr, input logic v);
        if (v && ^k) return 2'h2;
        if (pr == `PRIV_U || k == 2'h3) return 2'h1;
        if (k == `KIND_G_FENCE && pr == `PRIV_S && ctl[`CTRL_TVM_BIT]) return 2'h1;
        return 2'h0;
    endfunction
    function logic [1:0] exp_stage(input logic [1:0] k, input logic v);
        if (k == `KIND_G_FENCE) return `STAGE_G;
        return (k == `KIND_VS_FENCE || v) ? `STAGE_VS : `STAGE_HOST;
    endfunction
    task chk(input string what, input logic [63:0] exp, input logic [63:0] seen);
        check_count = check_count + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task axw(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        got = 1'b0;
        while (!got) begin
            @(posedge aclk);
            if (s_awvalid && s_awready) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready) s_wvalid <= 1'b0;
            got = s_bvalid;
        end
        s_bready <= 1'b0;
        chk("bresp", er, s_bresp);
    endtask
    task axr(input logic [4:0] a, input logic [31:0] ev, input logic [31:0] m, input logic [1:0] er);
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        got = 1'b0;
        while (!got) begin
            @(posedge aclk);
            if (s_arvalid && s_arready) s_arvalid <= 1'b0;
            got = s_rvalid;
        end
        s_rready <= 1'b0;
        chk("rresp", er, s_rresp);
        chk("rdata", ev, s_rdata & m);
    endtask
    task setr(input logic [4:0] c, input logic [15:0] g);
        ctl = c;
        gid = g;
        axw(`REG_CTRL, {27'h0, c}, `RESP_OKAY);
        axw(`REG_GUEST_ID, {16'h0, g}, `RESP_OKAY);
    endtask
    task fence(input logic [1:0] k, input logic [1:0] pr, input logic v, input logic z1, input logic z2);
        logic [1:0] ef;
        logic [63:0] a1, a2;
        integer nf;
        ef = exp_fault(k, pr, v);
        a1 = z1 ? 64'h0 : {$random(seed), $random(seed)};
        a2 = z2 ? 64'h0 : {$random(seed), $random(seed)};
        nf = n_flush;
        @(posedge aclk);
        req_valid <= 1'b1;
        req_kind <= k;
        req_priv <= pr;
        req_virt <= v;
        req_rs1_zero <= z1;
        req_rs2_zero <= z2;
        req_rs1_val <= a1;
        req_rs2_val <= a2;
        got = 1'b0;
        while (!got) begin
            @(posedge aclk);
            got = req_ready;
        end
        req_valid <= 1'b0;
        got = 1'b0;
        while (!got) begin
            @(posedge aclk);
            got = done_valid;
        end
        chk("fault", ef, {done_virtual, done_illegal});
        chk("flushes", ef == 2'h0, n_flush - nf);
        if (ef != 2'h0) n_bad = n_bad + 1;
        else begin
            n_ok = n_ok + 1;
            chk("stage", exp_stage(k, v), cap[100:99]);
            if (ctl[3:2] == `SCOPE_ALL) chk("all", 1, cap[98]);
            else if (ctl[3:2] == `SCOPE_ALL_VM) chk("use_vmid", 0, cap[95]);
            else if (k == `KIND_G_FENCE) begin
                chk("use_vmid", !z2, cap[95]);
                if (!z2) chk("vmid", a2[13:0], cap[77:64]);
                chk("combined", ctl[4], cap[94]);
                chk("use_addr", !z1 && !ctl[4], cap[97]);
            end else begin
                chk("use_addr", !z1, cap[97]);
                chk("use_asid", !z2, cap[96]);
                if (!z1) chk("addr", a1, cap[63:0]);
                if (!z2) chk("asid", a2[15:0], cap[93:78]);
                if (exp_stage(k, v) == `STAGE_VS) chk("vmid", gid[13:0], cap[77:64]);
            end
        end
    endtask
    task results;
        if (n_fail == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ----------
    // main sequence
    // ----------
    initial begin
        {seed, n_fail, check_count, n_ok, n_bad, n_flush} = {32'h9C2D, 160'h0};
        {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, req_valid} = 7'h0;
        {s_awaddr, s_araddr, s_wdata, req_kind, req_priv, req_virt, req_rs1_zero, req_rs2_zero} = 49'h0;
        {req_rs1_val, req_rs2_val, ctl, gid, ack_delay, stores_visible} = 154'h0;
        corner = '{12'h1A8, 12'h0C8, 12'h0DA, 12'h048, 12'h020, 12'h02C, 12'h04C, 12'h000, 12'h078, 12'h858,
            12'h438, 12'h248, 12'h00C};
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        axr(`REG_CTRL, 32'h0, 32'hFFFFFFFF, `RESP_OKAY);
        axr(`REG_GUEST_ID, 32'h0, 32'hFFFFFFFF, `RESP_OKAY);
        axr(`REG_FAULT_COUNT, 32'h0, 32'hFFFFFFFF, `RESP_OKAY);
        axr(`REG_STATUS, 32'h0, 32'h000000F0, `RESP_OKAY);
        axw(5'h14, 32'h1, `RESP_SLVERR);
        axr(5'h14, 32'h0, 32'hFFFFFFFF, `RESP_SLVERR);
        axw(`REG_FENCE_COUNT, 32'h55, `RESP_OKAY);
        axr(`REG_FENCE_COUNT, 32'h0, 32'hFFFFFFFF, `RESP_OKAY);
        axw(`REG_GUEST_ID, 32'hFFFFABCD, `RESP_OKAY);
        axr(`REG_GUEST_ID, 32'h0000ABCD, 32'hFFFFFFFF, `RESP_OKAY);
        for (i = 0; i < 13; i = i + 1) begin
            setr(corner[i][11:7], 16'h3F21);
            fence(corner[i][6:5], corner[i][4:3], corner[i][2], corner[i][1], corner[i][0]);
        end
        for (i = 0; i < 40; i = i + 1) begin
            r = $random(seed);
            nc = r[4:0];
            if (nc[3:2] == 2'h3) nc[3:2] = `SCOPE_PRECISE;
            p = (r[6:5] == 2'h2) ? `PRIV_M : r[6:5];
            setr(nc, r[31:16]);
            fence((r[11:10] == 2'h3) ? `KIND_G_FENCE : r[11:10], p, r[9:7] == 3'h0 && p == `PRIV_S, r[12], r[13]);
        end
        axr(`REG_FENCE_COUNT, n_ok, 32'hFFFFFFFF, `RESP_OKAY);
        axr(`REG_FAULT_COUNT, n_bad, 32'hFFFFFFFF, `RESP_OKAY);
        results;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail = n_fail + 1;
        $display("unexpected run length expected 20000 seen more");
        results;
    end
endmodule // tb
`default_nettype wire
